// ==== bench/cei_chk.sv ====
module cei_chk
  import cei_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cei_evt_t events,
  input wire logic packet_pending,
  input wire logic ctl_irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_lat; $rose(penable) && psel |=> pready; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
  property p_err_rdy; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("bad error answer");
  property p_st_rsvd;
    pready && !pwrite && paddr == CEI_OFS_STATUS |-> prdata[6:5] == 2'h0 && !prdata[3];
  endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("reserved status bit set");
  property p_st_pend;
    pready && !pwrite && paddr == CEI_OFS_STATUS && !ctl_irq_n |-> prdata[7];
  endproperty
  a_st_pend: assert property (p_st_pend) else $error("pending bit clear");
  // Flags and enables settle on one edge, the output register on the next
  property p_irq_fall;
    $fell(ctl_irq_n) |->
      (|$past(events, 2)) || $past(packet_pending, 2) || ($past(pready, 2) && $past(pwrite, 2));
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
  property p_irq_rise;
    $rose(ctl_irq_n) |-> !$past(packet_pending, 2) || ($past(pready, 2) && $past(pwrite, 2));
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
endmodule
bind cei_irq_ctrl cei_chk u_chk (
  .core_clk(core_clk),
  .srst(srst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .events(events),
  .packet_pending(packet_pending),
  .ctl_irq_n(ctl_irq_n)
);

// ==== bench/tb_host.sv ====
module tb_host
(
  input wire logic core_clk,
  input wire logic ctl_irq_n,
  output int falls
);
  timeunit 1ns;
  timeprecision 100ps;
  // Starts at the idle high level so reset release is not taken as an edge
  logic last = 1'b1;
  int fall_count = 0;
  assign falls = fall_count;
  // Edge-triggered host: a level held low is only seen once
  always @(posedge core_clk)
  begin
    last <= ctl_irq_n;
    if (last && !ctl_irq_n)
      fall_count <= fall_count + 1;
  end
endmodule

// ==== bench/tb_top.sv ====
module tb_top
  import cei_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, packet_pending = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, ctl_irq_n, er, pend;
  cei_evt_t events = '0;
  cei_mac_st_t mac_status = '0;
  logic [7:0] en, ev, fl;
  int fails = 0, tests_run = 0, cyc = 0, seed = 36, falls, k;
  always #12.5 core_clk = ~core_clk;
  cei_irq_ctrl #(
    .OST_CYCLES(8)
  ) dut (
    .core_clk(core_clk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .events(events),
    .packet_pending(packet_pending),
    .mac_status(mac_status),
    .ctl_irq_n(ctl_irq_n)
  );
  tb_host host (.core_clk(core_clk), .ctl_irq_n(ctl_irq_n), .falls(falls));
  task test_done();
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Event struct order is rx, txerr, txdone, link, dma from the top
  function logic [7:0] xfl(input logic [7:0] v, input logic [7:0] e);
    return {1'b0, v[7], v[0], v[1] & e[CEI_BIT_LINK], v[2], 1'b0, v[3], v[4]};
  endfunction
  initial
  begin
    tick(16);
    srst <= 0;
    apb(0, CEI_OFS_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0000_0000);
    tick(10);
    apb(0, CEI_OFS_STATUS, 32'h0000_0000);
    chk("clock_ready", rd, 32'h0000_0001);
    apb(0, 8'h0c, 32'h0000_0000);
    chk("unmapped", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0000_0000);
    // Corners: a write with no byte strobe and a write to status do nothing
    pstrb <= 4'h0;
    apb(1, CEI_OFS_ENABLE, 32'h0000_00ff);
    pstrb <= 4'hf;
    apb(1, CEI_OFS_STATUS, 32'h0000_00ff);
    apb(0, CEI_OFS_ENABLE, 32'h0000_0000);
    chk("strb0", rd, 32'h0000_0000);
    apb(0, CEI_OFS_STATUS, 32'h0000_0000);
    chk("st_ro", rd, 32'h0000_0001);
    // An event on the edge that lands a clear must win over the clear
    fork
      apb(1, CEI_OFS_FLAGS, 32'h0000_003b);
      begin
        tick(3);
        events <= 5'h10;
        tick(1);
        events <= '0;
      end
    join
    apb(0, CEI_OFS_FLAGS, 32'h0000_0000);
    chk("set_wins", rd, 32'h0000_0001);
    apb(1, CEI_OFS_FLAGS, 32'h0000_0001);
    repeat (40)
    begin
      en = 8'($random(seed)) & CEI_ENABLE_WMASK;
      ev = 8'($random(seed));
      packet_pending <= ev[7];
      mac_status <= ev[7:5];
      apb(1, CEI_OFS_ENABLE, {24'h00_0000, en});
      @(posedge core_clk);
      events <= ev[4:0];
      @(posedge core_clk);
      events <= '0;
      tick(3);
      fl = xfl(ev, en);
      pend = |(fl & en & CEI_SRC_MASK);
      chk("irq", ctl_irq_n, !(pend && en[CEI_BIT_GIE]));
      apb(0, CEI_OFS_FLAGS, 32'h0000_0000);
      chk("flags", rd, fl);
      apb(0, CEI_OFS_STATUS, 32'h0000_0000);
      chk("status", rd, {pend, 2'h0, ev[7], 1'b0, ev[6:5], 1'b1});
      k = falls;
      apb(1, CEI_OFS_ENABLE, {24'h00_0000, en & 8'h7f});
      tick(2);
      chk("gie_off", ctl_irq_n, 1'b1);
      apb(1, CEI_OFS_ENABLE, {24'h00_0000, en | 8'h80});
      // Output falls one edge after the write, the host counts it one edge later
      tick(3);
      chk("refire", falls - k, pend);
      apb(1, CEI_OFS_FLAGS, 32'h0000_003b);
      tick(2);
      chk("clear", ctl_irq_n, !(ev[7] & en[CEI_BIT_PKT]));
    end
    test_done();
  end
endmodule

// ==== rtl/cei_irq_ctrl.sv ====
// Summary of operation
// [R1] Six flags, each enabled, gated by global enable
// [R2] Pending summary computed from enabled raised flags
// [R3] Pending and global enable drive output low
// [R4] Pending summary at status bit 7, read-only
// [R5] Status bit 0 shows start-up timer expired
// [R6] Status bits 6, 5, 3 read zero
// [R7] Flags set regardless of enables, except link
// [R8] Output low until causes cleared or masked
// [R9] Clearing global enable returns output high
// [R10] Re-enabling with pending flag gives new edge
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
module cei_irq_ctrl
  import cei_pkg::*;
#(
  parameter int OST_CYCLES = CEI_OST_CYCLES
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cei_evt_t events,
  input wire logic packet_pending,
  input wire cei_mac_st_t mac_status,
  output logic ctl_irq_n
);

  cei_apb_state_t apb_state_reg;
  cei_apb_state_t apb_state_next;
  logic [7:0] source_enable_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  cei_mac_st_t mac_status_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic ctl_irq_n_reg;
  logic clock_ready;

  wire global_ctl_irq_enable;
  wire pending;
  wire [7:0] status_summary;
  wire sel_enable;
  wire sel_flags;
  wire sel_status;
  wire mapped;
  wire access;
  wire commit;
  wire wr_low_byte;
  wire wr_enable;
  wire wr_flags;
  wire [7:0] rd_byte;
  wire [31:0] rd_word;
  wire [7:0] enabled_src;
  wire irq_assert;

  // A zero start-up count would leave clock ready unreachable
  if (OST_CYCLES < 1)
  begin
    $error("OST_CYCLES must be at least 1");
  end

  cei_ost_timer #(
    .OST_CYCLES(OST_CYCLES)
  ) u_ost (
    .core_clk(core_clk),
    .srst(srst),
    .clock_ready(clock_ready)
  );

  // Decode shared by the three register selects
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return (addr == ofs);
  endfunction

  // Address decode
  assign sel_enable = reg_hit(paddr, CEI_OFS_ENABLE);
  assign sel_flags = reg_hit(paddr, CEI_OFS_FLAGS);
  assign sel_status = reg_hit(paddr, CEI_OFS_STATUS);
  assign mapped = sel_enable | sel_flags | sel_status;
  assign access = psel & penable & (apb_state_reg == CEI_APB_ACCESS);
  // Writes land only on the edge where the master sees pready high
  assign commit = psel & penable & pready_reg & pwrite & mapped;
  assign wr_low_byte = commit & pstrb[0];
  // Status is read-only, so it gets no write strobe
  assign wr_enable = wr_low_byte & sel_enable;
  assign wr_flags = wr_low_byte & sel_flags;

  assign global_ctl_irq_enable = source_enable_reg[CEI_BIT_GIE];
  assign enabled_src = flags_reg & source_enable_reg & CEI_SRC_MASK; // [R1]
  assign pending = |enabled_src; // [R2] [R8]
  assign irq_assert = pending & global_ctl_irq_enable; // [R3]

  // Status word; reserved and unimplemented bits tie to zero
  assign status_summary = {
    pending, // [R4]
    2'b00, // [R6]
    mac_status_reg.late_collision,
    1'b0, // [R6]
    mac_status_reg.receive_active,
    mac_status_reg.transmit_aborted,
    clock_ready // [R5]
  };

  assign rd_byte = sel_enable ? source_enable_reg :
                   sel_flags ? flags_reg :
                   sel_status ? status_summary : 8'h00;
  // Writes read back zero so a stale byte never follows a write
  assign rd_word = pwrite ? CEI_ZERO_WORD : {24'h00_0000, rd_byte};

  // Event capture; link change needs its own enable, the rest always latch
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[CEI_BIT_RXERR] = events.rx_error; // [R7]
    flag_set[CEI_BIT_TXERR] = events.tx_error; // [R7]
    flag_set[CEI_BIT_TXD] = events.tx_done; // [R7]
    flag_set[CEI_BIT_DMA] = events.dma_done; // [R7]
    flag_set[CEI_BIT_LINK] = events.link_change & source_enable_reg[CEI_BIT_LINK];
  end

  assign flag_clr = wr_flags ? (pwdata[7:0] & CEI_CLEAR_MASK) : 8'h00;

  // Set beats clear so an event in the clearing cycle is kept
  always_comb
  begin
    flags_next = ((flags_reg & ~flag_clr) | flag_set) & CEI_CLEAR_MASK;
    flags_next[CEI_BIT_PKT] = packet_pending; // [R7]
  end

  always_comb
  begin
    case (apb_state_reg)
      CEI_APB_IDLE:
        apb_state_next = (psel & ~penable) ? CEI_APB_ACCESS : CEI_APB_IDLE;
      CEI_APB_ACCESS:
        apb_state_next = access ? CEI_APB_DONE : CEI_APB_ACCESS;
      CEI_APB_DONE:
        apb_state_next = CEI_APB_IDLE;
      default:
        apb_state_next = CEI_APB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      apb_state_reg <= CEI_APB_IDLE;
    else
      apb_state_reg <= apb_state_next;
  end

  // One wait cycle lets read data come from a register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= CEI_ZERO_WORD;
    end
    else if (access)
    begin
      pready_reg <= 1'b1;
      pslverr_reg <= ~mapped;
      prdata_reg <= rd_word;
    end
    else
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      source_enable_reg <= CEI_ENABLE_RESET;
    else if (wr_enable)
      source_enable_reg <= pwdata[7:0] & CEI_ENABLE_WMASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      flags_reg <= CEI_FLAGS_RESET;
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      mac_status_reg <= '0;
    else
      mac_status_reg <= mac_status;
  end

  // Output is a plain level of pending and global enable, so dropping the
  // enable releases it and restoring it with a cause pending pulls it low again
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ctl_irq_n_reg <= 1'b1;
    else
      ctl_irq_n_reg <= ~irq_assert; // [R3] [R8] [R9] [R10]
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ctl_irq_n = ctl_irq_n_reg;

endmodule

// ==== rtl/cei_ost_timer.sv ====
module cei_ost_timer
  import cei_pkg::*;
#(
  parameter int OST_CYCLES = CEI_OST_CYCLES
)
(
  input wire logic core_clk,
  input wire logic srst,
  output logic clock_ready
);

  localparam int CW = $clog2(OST_CYCLES + 1);

  if (OST_CYCLES < 1)
  begin
    $error("OST_CYCLES must be at least 1");
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic clock_ready_reg;
  wire expired;

  assign expired = (count_reg == CW'(OST_CYCLES - 1));
  assign count_next = clock_ready_reg ? count_reg : count_reg + CW'(1);
  assign clock_ready = clock_ready_reg;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      count_reg <= '0;
      clock_ready_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      if (expired)
        clock_ready_reg <= 1'b1; // [R5]
    end
  end

endmodule

// ==== rtl/cei_pkg.sv ====
package cei_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] CEI_OFS_ENABLE = 8'h00;
  localparam logic [7:0] CEI_OFS_FLAGS = 8'h04;
  localparam logic [7:0] CEI_OFS_STATUS = 8'h08;

  // Enable register layout (flag register shares the source positions)
  localparam int CEI_BIT_GIE = 7;
  localparam int CEI_BIT_PKT = 6;
  localparam int CEI_BIT_DMA = 5;
  localparam int CEI_BIT_LINK = 4;
  localparam int CEI_BIT_TXD = 3;
  localparam int CEI_BIT_TXERR = 1;
  localparam int CEI_BIT_RXERR = 0;

  // Status register layout
  localparam int CEI_ST_PEND = 7;
  localparam int CEI_ST_LATE_COLLISION = 4;
  localparam int CEI_ST_RXACT = 2;
  localparam int CEI_ST_TRANSMIT_ABORTED = 1;
  localparam int CEI_ST_CLOCK_READY = 0;

  // Writable enable bits; bit 2 belongs to a path this block does not own
  localparam logic [7:0] CEI_ENABLE_WMASK = 8'hFB;
  // The six control sources within enable and flag registers
  localparam logic [7:0] CEI_SRC_MASK = 8'h7B;
  // Flags software may clear by writing 1; packet pending follows the buffer
  localparam logic [7:0] CEI_CLEAR_MASK = 8'h3B;

  localparam logic [7:0] CEI_ENABLE_RESET = 8'h00;
  localparam logic [7:0] CEI_FLAGS_RESET = 8'h00;
  localparam logic [31:0] CEI_ZERO_WORD = 32'h0000_0000;

  // Oscillator start-up time; plain default, no documented figure
  localparam int CEI_OST_TIME_NS = 100000;
  localparam int CEI_CLK_PERIOD_NS = 25;
  localparam int CEI_OST_CYCLES = (CEI_OST_TIME_NS + CEI_CLK_PERIOD_NS - 1) / CEI_CLK_PERIOD_NS;

  // One-cycle event pulses from the MAC core
  typedef struct packed {
    logic rx_error;
    logic tx_error;
    logic tx_done;
    logic link_change;
    logic dma_done;
  } cei_evt_t;

  // Transmit and receive status levels from the MAC core
  typedef struct packed {
    logic late_collision;
    logic receive_active;
    logic transmit_aborted;
  } cei_mac_st_t;

  typedef enum logic [1:0] {
    CEI_APB_IDLE = 2'b00,
    CEI_APB_ACCESS = 2'b01,
    CEI_APB_DONE = 2'b10
  } cei_apb_state_t;

endpackage
